// ==== hdl/dzf_top.sv ====
/*
   Converter control top: samples the serial audio pins, maps the four inputs
   onto eight channels, forces the middle channels to bipolar zero, drives
   the zero flags (six of them usable as plain outputs) and checks the system
   clock ratio against the sampling-rate class.
   Assumes mclk_i is the system clock and that bit and word clocks come from
   outside its domain, far slower than it.
*/
// Contract
// - Combined flag is the AND of the zero flags of channels one to six.
// - Flags one to six report zero data or act as plain outputs; seven, eight only zero.
// - Input a feeds channels 1/2, b 3/4, c 5/6, d 7/8, left then right.
// - Channels three to six are usable only up to 96 kHz.
// - 192 kHz is served only on inputs a and d.
// - All processing runs from the supplied system clock; nothing internal.
// - A control bit selects 64x oversampling, used for 192 kHz with 128x clock.
// - Channels three to six are forced to bipolar zero at 192 kHz.
module dzf_top #(
   parameter int ZERO_RUN = dzf_pkg::ZERO_RUN_DEF
) (
   // System clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Serial audio pins
   input wire logic bit_clock_i,
   input wire logic word_clock_i,
   input wire logic serial_audio_in_a_i,
   input wire logic serial_audio_in_b_i,
   input wire logic serial_audio_in_c_i,
   input wire logic serial_audio_in_d_i,
   // Control bits
   input wire dzf_pkg::dzf_fs_t fs_mode_i,
   input wire logic [dzf_pkg::NUM_MID-1:0] chan_disable_i,
   input wire logic oversample_64_i,
   input wire logic [dzf_pkg::NUM_GPO-1:0] general_purpose_output_en_i,
   input wire logic [dzf_pkg::NUM_GPO-1:0] general_purpose_output_level_i,
   // Channel samples
   output dzf_pkg::dzf_chan_bus_t chan_data_o,
   output logic [dzf_pkg::NUM_CH-1:0] chan_valid_o,
   // Flags
   output logic chan1_zero_flag_or_gpo_o,
   output logic chan2_zero_flag_or_gpo_o,
   output logic chan3_zero_flag_or_gpo_o,
   output logic chan4_zero_flag_or_gpo_o,
   output logic chan5_zero_flag_or_gpo_o,
   output logic chan6_zero_flag_or_gpo_o,
   output logic chan7_zero_flag_o,
   output logic chan8_zero_flag_o,
   output logic combined_zero_flag_o,
   // Status
   output logic oversample_64_o,
   output logic clock_ratio_ok_o
);
   import dzf_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Sync stages that must hold real pin samples before edges count
   localparam int FILL_W = 3;

   typedef struct packed {
      dzf_pins_t meta;
      dzf_pins_t pins;
      dzf_pins_t pins_d;
      logic [NUM_IN-1:0][SAMPLE_W-1:0] shift;
      dzf_chan_bus_t chan;
      logic [NUM_CH-1:0] stb;
      logic [CNT_W-1:0] mcnt;
      logic ratio_ok;
      logic [NUM_CH-1:0] flag_out;
      logic combined;
      logic osr64;
      logic [FILL_W-1:0] fill;
   } dzf_top_state_t;

   dzf_top_state_t state;
   dzf_top_state_t next_state;
   logic [1:0] rst_sync;
   logic rst_n;
   logic [NUM_CH-1:0] det_flag;
   logic [NUM_CH-1:0] samp_zero;

   // Tolerance band around a nominal ratio
   function automatic logic ratio_near(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] ratio);
      return (cnt + RATIO_TOL >= ratio) && (cnt <= ratio + RATIO_TOL);
   endfunction : ratio_near

   // Legal system clock ratios per rate class
   function automatic logic ratio_legal(input dzf_fs_t fs, input logic [CNT_W-1:0] cnt);
      logic ok;
      ok = 1'b0;
      case (fs)
         DZF_FS_192K: ok = ratio_near(cnt, RATIO_128) || ratio_near(cnt, RATIO_192);
         DZF_FS_96K: ok = ratio_near(cnt, RATIO_256) || ratio_near(cnt, RATIO_384)
            || ratio_near(cnt, RATIO_512);
         default: ok = ratio_near(cnt, RATIO_256) || ratio_near(cnt, RATIO_384)
            || ratio_near(cnt, RATIO_512) || ratio_near(cnt, RATIO_768);
      endcase
      return ok;
   endfunction : ratio_legal

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   // Async assert, two-flop release so the state and detector flops leave reset on one edge
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ----------------------------------------
   // Zero detectors, one per channel
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_det
         assign samp_zero[gi] = state.chan[gi] == BIPOLAR_ZERO;
         dzf_zero_det #(
            .ZERO_RUN(ZERO_RUN)
         ) u_det (
            .mclk_i(mclk_i),
            .resetn_i(rst_n),
            .sample_stb_i(state.stb[gi]),
            .sample_zero_i(samp_zero[gi]),
            .zero_flag_o(det_flag[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Pins pass two flops before any edge logic looks at them. Bit and word
   // clocks are edge-found by the system clock, which drives everything.
   always_comb begin
      logic bclk_rise;
      logic wclk_edge;
      logic wclk_rise;
      logic mid_off;
      logic [NUM_IN-1:0][SAMPLE_W-1:0] shifted;
      logic [CNT_W-1:0] period;
      bclk_rise = 1'b0;
      wclk_edge = 1'b0;
      wclk_rise = 1'b0;
      mid_off = 1'b0;
      shifted = '0;
      period = '0;
      next_state = state;
      next_state.meta = dzf_pins_t'({bit_clock_i, word_clock_i, serial_audio_in_d_i,
         serial_audio_in_c_i, serial_audio_in_b_i, serial_audio_in_a_i});
      next_state.pins = state.meta;
      next_state.pins_d = state.pins;
      // Reset leaves zeros in the chain; a pin idling high would fake an edge
      next_state.fill = {state.fill[FILL_W-2:0], 1'b1};
      bclk_rise = state.fill[FILL_W-1] && state.pins.bclk && !state.pins_d.bclk;
      wclk_edge = state.fill[FILL_W-1] && (state.pins.wclk != state.pins_d.wclk);
      wclk_rise = state.fill[FILL_W-1] && state.pins.wclk && !state.pins_d.wclk;
      // Bit taken on the edge that also ends a slot still belongs to that slot
      for (int i = 0; i < NUM_IN; i++) begin
         shifted[i] = bclk_rise ? {state.shift[i][SAMPLE_W-2:0], state.pins.data[i]} : state.shift[i];
      end
      next_state.shift = shifted;
      // High word clock is the left slot: it closes on the falling edge
      next_state.stb = '0;
      for (int i = 0; i < NUM_IN; i++) begin
         if (wclk_edge) begin
            next_state.chan[2*i + (wclk_rise ? 1 : 0)] = shifted[i];
            next_state.stb[2*i + (wclk_rise ? 1 : 0)] = 1'b1;
         end
      end
      // Middle channels are muted at 192 kHz or when disabled
      for (int i = 0; i < NUM_MID; i++) begin
         mid_off = (fs_mode_i == DZF_FS_192K) || chan_disable_i[i];
         if (mid_off) begin
            next_state.chan[MID_FIRST + i] = BIPOLAR_ZERO;
         end
      end
      // Clocks per word-clock period, saturating on a stalled word clock
      if (wclk_rise) begin
         period = state.mcnt + CNT_W'(1);
         next_state.ratio_ok = ratio_legal(fs_mode_i, period);
         next_state.mcnt = '0;
      end else if (state.mcnt != CNT_MAX) begin
         next_state.mcnt = state.mcnt + CNT_W'(1);
      end else begin
         next_state.ratio_ok = 1'b0;
      end
      // Flags one to six may be handed to software; seven and eight may not
      for (int i = 0; i < NUM_CH; i++) begin
         next_state.flag_out[i] = det_flag[i];
      end
      for (int i = 0; i < NUM_GPO; i++) begin
         if (general_purpose_output_en_i[i]) begin
            next_state.flag_out[i] = general_purpose_output_level_i[i];
         end
      end
      // Combined flag follows detection, not plain-output levels
      next_state.combined = &det_flag[NUM_GPO-1:0];
      next_state.osr64 = oversample_64_i;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------
   assign chan_data_o = state.chan;
   assign chan_valid_o = state.stb;
   assign chan1_zero_flag_or_gpo_o = state.flag_out[0];
   assign chan2_zero_flag_or_gpo_o = state.flag_out[1];
   assign chan3_zero_flag_or_gpo_o = state.flag_out[2];
   assign chan4_zero_flag_or_gpo_o = state.flag_out[3];
   assign chan5_zero_flag_or_gpo_o = state.flag_out[4];
   assign chan6_zero_flag_or_gpo_o = state.flag_out[5];
   assign chan7_zero_flag_o = state.flag_out[6];
   assign chan8_zero_flag_o = state.flag_out[7];
   assign combined_zero_flag_o = state.combined;
   assign oversample_64_o = state.osr64;
   assign clock_ratio_ok_o = state.ratio_ok;

endmodule : dzf_top

// ==== hdl/dzf_pkg.sv ====
/*
   Package for the converter control block: channel counts, sample width,
   clock ratio figures, the sampling-rate class and the carrier types.
   Assumes nothing of its surroundings; every other design file imports it.
*/
package dzf_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int SAMPLE_W = 24;
   localparam int NUM_IN = 4;
   localparam int NUM_CH = 8;
   localparam int NUM_GPO = 6;
   localparam int NUM_MID = 4;
   localparam int CNT_W = 12;

   // ----------------------------------------
   // System clock ratios (clocks per sample)
   // ----------------------------------------
   localparam logic [CNT_W-1:0] RATIO_128 = 12'h080;
   localparam logic [CNT_W-1:0] RATIO_192 = 12'h0C0;
   localparam logic [CNT_W-1:0] RATIO_256 = 12'h100;
   localparam logic [CNT_W-1:0] RATIO_384 = 12'h180;
   localparam logic [CNT_W-1:0] RATIO_512 = 12'h200;
   localparam logic [CNT_W-1:0] RATIO_768 = 12'h300;
   localparam logic [CNT_W-1:0] RATIO_TOL = 12'h002;
   localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;

   // ----------------------------------------
   // Defaults
   // ----------------------------------------
   localparam int ZERO_RUN_DEF = 1024;
   localparam logic [SAMPLE_W-1:0] BIPOLAR_ZERO = 24'h000000;
   localparam int MID_FIRST = 2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      DZF_FS_NORMAL,
      DZF_FS_96K,
      DZF_FS_192K
   } dzf_fs_t;

   // Audio pins as sampled: data[0] is input a
   typedef struct packed {
      logic bclk;
      logic wclk;
      logic [NUM_IN-1:0] data;
   } dzf_pins_t;

   typedef logic [NUM_CH-1:0][SAMPLE_W-1:0] dzf_chan_bus_t;

endpackage : dzf_pkg

// ==== hdl/dzf_zero_det.sv ====
/*
   Zero-data detector for one output channel: the flag rises after a run of
   consecutive all-zero samples and falls on the first nonzero sample.
   Assumes a synchronous, already released reset and a one-cycle sample
   strobe on the same clock.
*/
module dzf_zero_det #(
   parameter int ZERO_RUN = dzf_pkg::ZERO_RUN_DEF
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Sample
   input wire logic sample_stb_i,
   input wire logic sample_zero_i,
   // Flag
   output logic zero_flag_o
);
   import dzf_pkg::*;

   localparam int RUN_W = $clog2(ZERO_RUN + 1);
   localparam logic [RUN_W-1:0] RUN_END = RUN_W'(ZERO_RUN);

   typedef struct packed {
      logic [RUN_W-1:0] run;
      logic flag;
   } dzf_det_state_t;

   dzf_det_state_t state;
   dzf_det_state_t next_state;

   // Count zero samples; saturate so a long silence never wraps the flag off
   always_comb begin
      next_state = state;
      if (sample_stb_i) begin
         if (!sample_zero_i) begin
            next_state.run = '0;
            next_state.flag = 1'b0;
         end else if (state.run != RUN_END) begin
            next_state.run = state.run + RUN_W'(1);
            next_state.flag = (state.run + RUN_W'(1)) == RUN_END;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign zero_flag_o = state.flag;

endmodule : dzf_zero_det

// ==== testbench/dzf_chk.sv ====
/*
   Port checker for dzf_top, bound at the foot of this file.
   Assumes one clock; raw async reset disables every property.
*/
module dzf_chk #(
   parameter int ZERO_RUN = dzf_pkg::ZERO_RUN_DEF
) (
   // Clock, reset and controls
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire dzf_pkg::dzf_fs_t fs_mode_i,
   input wire logic [3:0] chan_disable_i,
   input wire logic oversample_64_i,
   input wire logic [5:0] general_purpose_output_en_i,
   input wire logic [5:0] general_purpose_output_level_i,
   // Outputs of the top
   input wire dzf_pkg::dzf_chan_bus_t chan_data_o,
   input wire logic [7:0] chan_valid_o,
   input wire logic chan1_zero_flag_or_gpo_o,
   input wire logic chan2_zero_flag_or_gpo_o,
   input wire logic chan3_zero_flag_or_gpo_o,
   input wire logic chan4_zero_flag_or_gpo_o,
   input wire logic chan5_zero_flag_or_gpo_o,
   input wire logic chan6_zero_flag_or_gpo_o,
   input wire logic chan7_zero_flag_o,
   input wire logic chan8_zero_flag_o,
   input wire logic combined_zero_flag_o,
   input wire logic oversample_64_o,
   input wire logic clock_ratio_ok_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import dzf_pkg::*;
   // Flags one to six as a vector, nonzero middle channels
   logic [5:0] flg;
   logic [3:0] mid_nz;
   assign flg = {chan6_zero_flag_or_gpo_o, chan5_zero_flag_or_gpo_o, chan4_zero_flag_or_gpo_o,
                 chan3_zero_flag_or_gpo_o, chan2_zero_flag_or_gpo_o, chan1_zero_flag_or_gpo_o};
   for (genvar i = 0; i < 4; i++) begin : g_mid
      assign mid_nz[i] = |chan_data_o[i+MID_FIRST];
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);
   // ------
   // Flags
   // ------
   AST_COMB_AND: assert property (
      (general_purpose_output_en_i == '0 && $past(general_purpose_output_en_i) == '0)
      |-> combined_zero_flag_o == &flg) else $error("combined flag is not the flag AND");
   AST_GPO_LEVEL: assert property (((flg ^ $past(general_purpose_output_level_i))
      & $past(general_purpose_output_en_i)) == '0) else $error("plain output level wrong");
   AST_Z7_SRC: assert property ($rose(chan7_zero_flag_o) |-> chan_data_o[6] == '0 &&
      ($past(chan_valid_o[6]) || $past(chan_valid_o[6], 2) || $past(chan_valid_o[6], 3)))
      else $error("flag 7 rose alone");
   AST_Z8_SRC: assert property ($rose(chan8_zero_flag_o) |-> chan_data_o[7] == '0 &&
      ($past(chan_valid_o[7]) || $past(chan_valid_o[7], 2) || $past(chan_valid_o[7], 3)))
      else $error("flag 8 rose alone");
   // ------
   // Channels
   // ------
   AST_PULSE: assert property (chan_valid_o != '0 |=> chan_valid_o == '0) else $error("load pulse too long");
   AST_PAIR: assert property (chan_valid_o[0] == chan_valid_o[6] &&
      ((chan_valid_o & 8'h55) == '0 || (chan_valid_o & 8'hAA) == '0)) else $error("load order wrong");
   AST_HOLD: assert property ($changed(chan_data_o[0]) |-> chan_valid_o[0]) else $error("ch1 changed unloaded");
   AST_FS192: assert property ($past(fs_mode_i) == DZF_FS_192K |-> mid_nz == '0) else $error("mid not zero");
   AST_DIS: assert property ((mid_nz & $past(chan_disable_i)) == '0) else $error("disabled channel live");
   AST_OVS: assert property (oversample_64_o == $past(oversample_64_i)) else $error("oversample copy wrong");
   COV_LOAD: cover property (chan_valid_o == 8'h55);
   COV_ALLZ: cover property ($rose(combined_zero_flag_o));
   COV_RATIO: cover property ($rose(clock_ratio_ok_o));
endmodule : dzf_chk

bind dzf_top dzf_chk #(.ZERO_RUN(ZERO_RUN)) u_chk (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .fs_mode_i(fs_mode_i), .chan_disable_i(chan_disable_i),
   .oversample_64_i(oversample_64_i), .general_purpose_output_en_i(general_purpose_output_en_i),
   .general_purpose_output_level_i(general_purpose_output_level_i), .chan_data_o(chan_data_o),
   .chan_valid_o(chan_valid_o), .chan1_zero_flag_or_gpo_o(chan1_zero_flag_or_gpo_o),
   .chan2_zero_flag_or_gpo_o(chan2_zero_flag_or_gpo_o), .chan3_zero_flag_or_gpo_o(chan3_zero_flag_or_gpo_o),
   .chan4_zero_flag_or_gpo_o(chan4_zero_flag_or_gpo_o), .chan5_zero_flag_or_gpo_o(chan5_zero_flag_or_gpo_o),
   .chan6_zero_flag_or_gpo_o(chan6_zero_flag_or_gpo_o), .chan7_zero_flag_o(chan7_zero_flag_o),
   .chan8_zero_flag_o(chan8_zero_flag_o), .combined_zero_flag_o(combined_zero_flag_o),
   .oversample_64_o(oversample_64_o), .clock_ratio_ok_o(clock_ratio_ok_o));

// ==== testbench/dzf_src.sv ====
/*
   Audio source model: bit clock, word clock, four serial data lines.
   The bench calls frame(); the bit clock stands still between frames.
*/
module dzf_src (
   // Serial audio link
   output logic bit_clock_o,
   output logic word_clock_o,
   output logic [3:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle: clock low, word clock high
   initial begin
      bit_clock_o = 1'b0;
      word_clock_o = 1'b1;
      data_o = 4'h5;
   end
   // Left slot high, right slot low, MSB first, 160 ns bit period
   task automatic frame(input logic [7:0][23:0] smp, input int bits);
      logic [31:0] w;
      #3;
      for (int h = 0; h < 2; h++) begin
         for (int b = bits - 1; b >= 0; b--) begin
            bit_clock_o = 1'b0;
            if (b == bits - 1) begin
               word_clock_o = (h == 0);
            end
            for (int i = 0; i < 4; i++) begin
               w = {8'hA5, smp[2*i+h]};
               data_o[i] = w[b];
            end
            #80 bit_clock_o = 1'b1;
            #80;
         end
      end
      // Closing rise loads the right slot; released data must not look held
      bit_clock_o = 1'b0;
      word_clock_o = 1'b1;
      data_o = ~data_o;
   endtask : frame
endmodule : dzf_src

// ==== testbench/tb_dzf_top.sv ====
/*
   Self-checking bench for dzf_top with the audio source model.
   Assumes dzf_src and the bound dzf_chk are compiled with it.
*/
`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module tb_dzf_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dzf_pkg::*;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   wire bit_clock_i, word_clock_i;
   wire serial_audio_in_a_i, serial_audio_in_b_i, serial_audio_in_c_i, serial_audio_in_d_i;
   dzf_fs_t fs_mode_i = DZF_FS_NORMAL;
   logic [3:0] chan_disable_i = 4'h0;
   logic oversample_64_i = 1'b0;
   logic [5:0] general_purpose_output_en_i = 6'h00;
   logic [5:0] general_purpose_output_level_i = 6'h00;
   dzf_chan_bus_t chan_data_o;
   logic [7:0] chan_valid_o;
   logic chan1_zero_flag_or_gpo_o, chan2_zero_flag_or_gpo_o, chan3_zero_flag_or_gpo_o;
   logic chan4_zero_flag_or_gpo_o, chan5_zero_flag_or_gpo_o, chan6_zero_flag_or_gpo_o;
   logic chan7_zero_flag_o, chan8_zero_flag_o, combined_zero_flag_o, oversample_64_o, clock_ratio_ok_o;
   wire [8:0] zf = {combined_zero_flag_o, chan8_zero_flag_o, chan7_zero_flag_o, chan6_zero_flag_or_gpo_o,
                    chan5_zero_flag_or_gpo_o, chan4_zero_flag_or_gpo_o, chan3_zero_flag_or_gpo_o,
                    chan2_zero_flag_or_gpo_o, chan1_zero_flag_or_gpo_o};
   logic [23:0] expq [8][$];
   logic [23:0] e;
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;

   dzf_top #(.ZERO_RUN(4)) u_dut (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .bit_clock_i(bit_clock_i), .word_clock_i(word_clock_i),
      .serial_audio_in_a_i(serial_audio_in_a_i), .serial_audio_in_b_i(serial_audio_in_b_i),
      .serial_audio_in_c_i(serial_audio_in_c_i), .serial_audio_in_d_i(serial_audio_in_d_i),
      .fs_mode_i(fs_mode_i), .chan_disable_i(chan_disable_i), .oversample_64_i(oversample_64_i),
      .general_purpose_output_en_i(general_purpose_output_en_i),
      .general_purpose_output_level_i(general_purpose_output_level_i),
      .chan_data_o(chan_data_o), .chan_valid_o(chan_valid_o),
      .chan1_zero_flag_or_gpo_o(chan1_zero_flag_or_gpo_o), .chan2_zero_flag_or_gpo_o(chan2_zero_flag_or_gpo_o),
      .chan3_zero_flag_or_gpo_o(chan3_zero_flag_or_gpo_o), .chan4_zero_flag_or_gpo_o(chan4_zero_flag_or_gpo_o),
      .chan5_zero_flag_or_gpo_o(chan5_zero_flag_or_gpo_o), .chan6_zero_flag_or_gpo_o(chan6_zero_flag_or_gpo_o),
      .chan7_zero_flag_o(chan7_zero_flag_o), .chan8_zero_flag_o(chan8_zero_flag_o),
      .combined_zero_flag_o(combined_zero_flag_o), .oversample_64_o(oversample_64_o),
      .clock_ratio_ok_o(clock_ratio_ok_o));
   dzf_src u_src (.bit_clock_o(bit_clock_i), .word_clock_o(word_clock_i),
      .data_o({serial_audio_in_d_i, serial_audio_in_c_i, serial_audio_in_b_i, serial_audio_in_a_i}));

   // ------
   // Clock, hang guard, verdict
   // ------
   initial begin
      forever #10 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end
   task automatic results;
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   // Each load takes the oldest note of its channel; mid-cycle sampling avoids races
   always @(negedge mclk_i) begin
      for (int c = 0; c < 8; c++) begin
         if (chan_valid_o[c] === 1'b1 && expq[c].size() > 0) begin
            e = expq[c].pop_front();
            `CHK(chan_data_o[c], e)
         end
      end
   end
   // Send n frames; forced channels expect bipolar zero, other channels in short slots carry no note
   task automatic send(input int n, input int bits, input logic [7:0] zm);
      logic [7:0][23:0] s;
      repeat (n) begin
         for (int c = 0; c < 8; c++) begin
            s[c] = zm[c] ? 24'h000000 : 24'($urandom_range(24'hFFFFFF, 1));
            if (c inside {[2:5]} && (fs_mode_i == DZF_FS_192K || chan_disable_i[c-2])) begin
               expq[c].push_back(BIPOLAR_ZERO);
            end else if (bits >= 24) begin
               expq[c].push_back(s[c]);
            end
         end
         u_src.frame(s, bits);
      end
      repeat (8) @(negedge mclk_i);
   endtask : send

   // ------
   // Main sequence
   // ------
   initial begin
      void'($urandom(32'h2EA7));
      repeat (6) @(negedge mclk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      // Rate classes against 512, 384 and 256 clocks per sample
      for (int i = 0; i < 8; i++) begin
         fs_mode_i = (i < 3) ? DZF_FS_NORMAL : (i < 6) ? DZF_FS_96K : DZF_FS_192K;
         send(2, 32 - 8 * (i % 3), 8'h00);
         `CHK(clock_ratio_ok_o, 1'(i < 6))
      end
      fs_mode_i = DZF_FS_NORMAL;
      for (int i = 0; i < 4; i++) begin
         chan_disable_i = 4'(1 << i);
         send(1, 32, 8'h00);
      end
      chan_disable_i = 4'h0;
      // Zero runs, plain outputs, then one live channel
      oversample_64_i = 1'b1;
      send(4, 32, 8'hFF);
      `CHK(zf, 9'h1FF)
      `CHK(oversample_64_o, 1'b1)
      general_purpose_output_level_i = 6'($urandom());
      general_purpose_output_en_i = 6'h3F;
      repeat (2) @(negedge mclk_i);
      `CHK(zf, {3'h7, general_purpose_output_level_i})
      send(1, 32, 8'hFE);
      `CHK(zf, {3'h3, general_purpose_output_level_i})
      general_purpose_output_en_i = 6'h00;
      repeat (2) @(negedge mclk_i);
      `CHK(zf, 9'h0FE)
      for (int c = 0; c < 8; c++) begin
         `CHK(expq[c].size(), 0)
      end
      results();
   end
endmodule : tb_dzf_top
